// >>> hdl/ctmb_tx_status.v
// Purpose: transmit mailbox status register of a CAN controller
// Assumes: engine events are one-cycle pulses synchronous to mclk
// Notes: register port reads answer one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
`include "ctmb_defs.vh"

module ctmb_tx_status #(
    parameter ID_W = 29
) (
    input wire mclk,
    input wire rstn,
    input wire [`CTMB_ADDR_W-1:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output reg [31:0] regRdData_ff,
    input wire [2:0] newReq,
    input wire [ID_W-1:0] reqId0,
    input wire [ID_W-1:0] reqId1,
    input wire [ID_W-1:0] reqId2,
    input wire [2:0] txStart,
    input wire [2:0] txSuccess,
    input wire [2:0] txArbLost,
    input wire [2:0] txError,
    input wire [2:0] txRelease,
    output wire [2:0] cancelReq,
    output wire [2:0] mboxPending,
    output wire orderByReq,
    output wire irq
);

// ==========================================================
// reset release
reg rstMeta_ff;
reg rstSyncN;

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        rstMeta_ff <= 1'b0;
        rstSyncN <= 1'b0;
    end else begin
        rstMeta_ff <= 1'b1;
        rstSyncN <= rstMeta_ff;
    end
end

// ==========================================================
// register decode
wire wrCtrl;
wire wrTsts;
wire wrIrqClr;
wire wrIrqEn;

assign wrCtrl = regWrEn & (regAddr == `CTMB_CTRL_OFF);
assign wrTsts = regWrEn & (regAddr == `CTMB_TSTS_OFF);
assign wrIrqClr = regWrEn & (regAddr == `CTMB_IRQ_CLR_OFF);
assign wrIrqEn = regWrEn & (regAddr == `CTMB_IRQ_EN_OFF);

// ==========================================================
// control register
reg orderRule_ff;

always @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
        orderRule_ff <= `CTMB_ORDER_RST;
    end else if (wrCtrl) begin
        orderRule_ff <= regWrData[`CTMB_ORDER_POS];
    end
end

assign orderByReq = orderRule_ff;

// ==========================================================
// identifiers latched at request time
reg [ID_W-1:0] id0_ff;
reg [ID_W-1:0] id1_ff;
reg [ID_W-1:0] id2_ff;

always @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
        id0_ff <= {ID_W{1'b0}};
        id1_ff <= {ID_W{1'b0}};
        id2_ff <= {ID_W{1'b0}};
    end else begin
        if (newReq[0]) begin
            id0_ff <= reqId0;
        end
        if (newReq[1]) begin
            id1_ff <= reqId1;
        end
        if (newReq[2]) begin
            id2_ff <= reqId2;
        end
    end
end

// ==========================================================
// per-mailbox flags
wire [2:0] pendingW;
wire [2:0] cancelW;
wire [2:0] cmplW;
wire [2:0] succW;
wire [2:0] arbW;
wire [2:0] errW;
wire [2:0] cmplEvent;

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gMbox
        // zero bits of the write leave every flag alone
        ctmb_mbox_flags uFlags (
            .mclk(mclk),
            .rstSyncN(rstSyncN),
            .newReq(newReq[gi]),
            .txStart(txStart[gi]),
            .txSuccess(txSuccess[gi]),
            .txArbLost(txArbLost[gi]),
            .txError(txError[gi]),
            .txRelease(txRelease[gi]),
            .swCancelSet(wrTsts & regWrData[gi*`CTMB_MB_STRIDE+`CTMB_CANCEL_POS]),
            .swClrCmpl(wrTsts & regWrData[gi*`CTMB_MB_STRIDE+`CTMB_CMPL_POS]),
            .swClrSucc(wrTsts & regWrData[gi*`CTMB_MB_STRIDE+`CTMB_SUCC_POS]),
            .swClrArb(wrTsts & regWrData[gi*`CTMB_MB_STRIDE+`CTMB_ARB_POS]),
            .swClrErr(wrTsts & regWrData[gi*`CTMB_MB_STRIDE+`CTMB_ERR_POS]),
            .pending_ff(pendingW[gi]),
            .cancel_ff(cancelW[gi]),
            .cmpl_ff(cmplW[gi]),
            .succ_ff(succW[gi]),
            .arb_ff(arbW[gi]),
            .err_ff(errW[gi]),
            .cmplEvent(cmplEvent[gi])
        );
    end
endgenerate

assign cancelReq = cancelW;
assign mboxPending = pendingW;

// ==========================================================
// request-order ages
// age 0 is the newest request; older pending mailboxes count up
reg [1:0] age0_ff;
reg [1:0] age1_ff;
reg [1:0] age2_ff;
wire anyNew;

assign anyNew = |newReq;

function [1:0] nextAge;
    input [1:0] age;
    input isNew;
    input isPend;
    input bump;
    begin
        if (isNew) begin
            nextAge = 2'h0;
        end else if (isPend & bump & (age < `CTMB_AGE_MAX)) begin
            nextAge = age + 2'h1;
        end else begin
            nextAge = age;
        end
    end
endfunction

always @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
        age0_ff <= 2'h0;
        age1_ff <= 2'h0;
        age2_ff <= 2'h0;
    end else begin
        age0_ff <= nextAge(age0_ff, newReq[0], pendingW[0], anyNew);
        age1_ff <= nextAge(age1_ff, newReq[1], pendingW[1], anyNew);
        age2_ff <= nextAge(age2_ff, newReq[2], pendingW[2], anyNew);
    end
end

// ==========================================================
// priority ranking
wire [2:0] lowestPrio;
wire [1:0] lowestIdx;

ctmb_prio_rank #(
    .ID_W(ID_W)
) uRank (
    .pending(pendingW),
    .id0(id0_ff),
    .id1(id1_ff),
    .id2(id2_ff),
    .age0(age0_ff),
    .age1(age1_ff),
    .age2(age2_ff),
    .orderByReq(orderRule_ff),
    .lowestOneHot(lowestPrio),
    .lowestIdx(lowestIdx)
);

// ==========================================================
// mailbox number field
wire [2:0] emptyW;
reg [1:0] mailboxNumber;

assign emptyW = ~pendingW;

always @* begin
    mailboxNumber = `CTMB_MNR_RST;
    if (emptyW[0]) begin
        mailboxNumber = 2'h0;
    end else if (emptyW[1]) begin
        mailboxNumber = 2'h1;
    end else if (emptyW[2]) begin
        mailboxNumber = 2'h2;
    end else begin
        mailboxNumber = lowestIdx;
    end
end

// ==========================================================
// status word
reg [31:0] tstsWord;
integer mi;

always @* begin
    tstsWord = 32'h0;
    tstsWord[`CTMB_LP_POS+2:`CTMB_LP_POS] = lowestPrio;
    tstsWord[`CTMB_EMPTY_POS+2:`CTMB_EMPTY_POS] = emptyW;
    tstsWord[`CTMB_MNR_POS+1:`CTMB_MNR_POS] = mailboxNumber;
    for (mi = 0; mi < 3; mi = mi + 1) begin
        tstsWord[mi*`CTMB_MB_STRIDE+`CTMB_CANCEL_POS] = cancelW[mi];
        tstsWord[mi*`CTMB_MB_STRIDE+`CTMB_ERR_POS] = errW[mi];
        tstsWord[mi*`CTMB_MB_STRIDE+`CTMB_ARB_POS] = arbW[mi];
        tstsWord[mi*`CTMB_MB_STRIDE+`CTMB_SUCC_POS] = succW[mi];
        tstsWord[mi*`CTMB_MB_STRIDE+`CTMB_CMPL_POS] = cmplW[mi];
    end
end

// ==========================================================
// interrupt: completion events per mailbox
reg [2:0] irqSts_ff;
reg [2:0] irqEn_ff;
wire [2:0] nxt_irqSts;

// a completion landing with its clear stays visible
assign nxt_irqSts = cmplEvent | (irqSts_ff & ~({3{wrIrqClr}} & regWrData[2:0]));

always @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
        irqSts_ff <= 3'h0;
        irqEn_ff <= 3'h0;
    end else begin
        irqSts_ff <= nxt_irqSts;
        if (wrIrqEn) begin
            irqEn_ff <= regWrData[2:0];
        end
    end
end

assign irq = |(irqSts_ff & irqEn_ff);

// ==========================================================
// read port
reg [31:0] nxt_rdData;

always @* begin
    nxt_rdData = 32'h0;
    case (regAddr)
        `CTMB_CTRL_OFF: begin
            nxt_rdData[`CTMB_ORDER_POS] = orderRule_ff;
        end
        `CTMB_TSTS_OFF: begin
            nxt_rdData = tstsWord;
        end
        `CTMB_IRQ_STS_OFF: begin
            nxt_rdData[2:0] = irqSts_ff;
        end
        `CTMB_IRQ_EN_OFF: begin
            nxt_rdData[2:0] = irqEn_ff;
        end
        default: begin
            nxt_rdData = 32'h0;
        end
    endcase
end

// data holds only in the cycle after the strobe
always @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
        regRdData_ff <= 32'h0;
    end else if (regRdEn) begin
        regRdData_ff <= nxt_rdData;
    end else begin
        regRdData_ff <= 32'h0;
    end
end

endmodule // ctmb_tx_status

`default_nettype wire

// >>> hdl/ctmb_defs.vh
// Purpose: constants of the transmit mailbox status block
// Assumes: byte addresses on the register port, 32-bit data
// Notes: definitions only
`ifndef CTMB_DEFS_VH
`define CTMB_DEFS_VH

// ==========================================================
// register offsets
`define CTMB_ADDR_W 10
`define CTMB_CTRL_OFF 10'h004
`define CTMB_TSTS_OFF 10'h008
`define CTMB_IRQ_STS_OFF 10'h010
`define CTMB_IRQ_CLR_OFF 10'h014
`define CTMB_IRQ_EN_OFF 10'h018

// ==========================================================
// status register fields
`define CTMB_LP_POS 29
`define CTMB_EMPTY_POS 26
`define CTMB_MNR_POS 24
`define CTMB_MB_STRIDE 8
`define CTMB_CANCEL_POS 7
`define CTMB_ERR_POS 3
`define CTMB_ARB_POS 2
`define CTMB_SUCC_POS 1
`define CTMB_CMPL_POS 0

// ==========================================================
// control register field, reset values and age limit
`define CTMB_ORDER_POS 2
`define CTMB_ORDER_RST 1'h0
`define CTMB_MNR_RST 2'h0
`define CTMB_AGE_MAX 2'h2

`endif

// >>> hdl/ctmb_mbox_flags.v
// Purpose: per-mailbox pending state, cancel bit and outcome flags
// Assumes: engine event inputs are one-cycle pulses; the sw inputs are register write strobes
// Notes: every hardware set wins over a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none

module ctmb_mbox_flags (
    input wire mclk,
    input wire rstSyncN,
    input wire newReq,
    input wire txStart,
    input wire txSuccess,
    input wire txArbLost,
    input wire txError,
    input wire txRelease,
    input wire swCancelSet,
    input wire swClrCmpl,
    input wire swClrSucc,
    input wire swClrArb,
    input wire swClrErr,
    output reg pending_ff,
    output reg cancel_ff,
    output reg cmpl_ff,
    output reg succ_ff,
    output reg arb_ff,
    output reg err_ff,
    output wire cmplEvent
);

// ==========================================================
// next state
wire endMsg;
wire cmplClr;
wire cmplClearing;
wire nxt_pending;
wire nxt_cancel;
wire nxt_cmpl;
wire nxt_succ;
wire nxt_arb;
wire nxt_err;

assign endMsg = txSuccess | txRelease;
assign cmplEvent = endMsg;
assign cmplClr = swClrCmpl | newReq;
assign cmplClearing = cmpl_ff & cmplClr & ~endMsg;
assign nxt_pending = newReq | (pending_ff & ~endMsg);
// free mailbox ignores the set; cleared once the message is gone
assign nxt_cancel = (swCancelSet & pending_ff & ~endMsg) | (cancel_ff & pending_ff & ~endMsg);
assign nxt_cmpl = endMsg | (cmpl_ff & ~cmplClr);
assign nxt_succ = txSuccess | (succ_ff & ~(txArbLost | txError | swClrSucc | cmplClearing));
assign nxt_arb = txArbLost | (arb_ff & ~(txStart | swClrArb | cmplClearing));
assign nxt_err = txError | (err_ff & ~(txStart | swClrErr | cmplClearing));

// ==========================================================
// flops
always @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
        pending_ff <= 1'h0;
        cancel_ff <= 1'h0;
        cmpl_ff <= 1'h0;
        succ_ff <= 1'h0;
        arb_ff <= 1'h0;
        err_ff <= 1'h0;
    end else begin
        pending_ff <= nxt_pending;
        cancel_ff <= nxt_cancel;
        cmpl_ff <= nxt_cmpl;
        succ_ff <= nxt_succ;
        arb_ff <= nxt_arb;
        err_ff <= nxt_err;
    end
end

endmodule // ctmb_mbox_flags

`default_nettype wire

// >>> hdl/ctmb_prio_rank.v
// Purpose: finds the pending mailbox that would be sent last
// Assumes: ages are distinct among pending mailboxes
// Notes: equal keys fall back to the higher mailbox index ranking last
`timescale 1ns/1ns
`default_nettype none

module ctmb_prio_rank #(
    parameter ID_W = 29
) (
    input wire [2:0] pending,
    input wire [ID_W-1:0] id0,
    input wire [ID_W-1:0] id1,
    input wire [ID_W-1:0] id2,
    input wire [1:0] age0,
    input wire [1:0] age1,
    input wire [1:0] age2,
    input wire orderByReq,
    output reg [2:0] lowestOneHot,
    output reg [1:0] lowestIdx
);

// ==========================================================
// ranking
// true when mailbox m ranks below mailbox n
function ranksBelow;
    input [ID_W-1:0] idM;
    input [ID_W-1:0] idN;
    input [1:0] ageM;
    input [1:0] ageN;
    input mGreater;
    input byReq;
    begin
        if (byReq) begin
            ranksBelow = (ageM < ageN) | ((ageM == ageN) & mGreater);
        end else begin
            ranksBelow = (idM > idN) | ((idM == idN) & mGreater);
        end
    end
endfunction

wire b01;
wire b02;
wire b10;
wire b12;
wire b20;
wire b21;
wire [2:0] lowestAny;

assign b01 = ranksBelow(id0, id1, age0, age1, 1'b0, orderByReq);
assign b02 = ranksBelow(id0, id2, age0, age2, 1'b0, orderByReq);
assign b10 = ranksBelow(id1, id0, age1, age0, 1'b1, orderByReq);
assign b12 = ranksBelow(id1, id2, age1, age2, 1'b0, orderByReq);
assign b20 = ranksBelow(id2, id0, age2, age0, 1'b1, orderByReq);
assign b21 = ranksBelow(id2, id1, age2, age1, 1'b1, orderByReq);

assign lowestAny[0] = pending[0] & (~pending[1] | b01) & (~pending[2] | b02);
assign lowestAny[1] = pending[1] & (~pending[0] | b10) & (~pending[2] | b12);
assign lowestAny[2] = pending[2] & (~pending[0] | b20) & (~pending[1] | b21);

always @* begin
    lowestOneHot = 3'h0;
    lowestIdx = 2'h0;
    // only meaningful with two or more pending
    if ((pending[0] & pending[1]) | (pending[0] & pending[2]) | (pending[1] & pending[2])) begin
        lowestOneHot = lowestAny;
    end
    if (lowestAny[2]) begin
        lowestIdx = 2'h2;
    end else if (lowestAny[1]) begin
        lowestIdx = 2'h1;
    end
end

endmodule // ctmb_prio_rank

`default_nettype wire

// >>> verification/ctmb_tx_status_props.sv
// Purpose: port-level checks of the transmit mailbox status block
// Assumes: one clock, rstn active low
// Notes: status word answers describe the state seen at the read strobe
`timescale 1ns/1ns
`default_nettype none
`include "ctmb_defs.vh"

module ctmb_tx_status_props (
    input wire mclk,
    input wire rstn,
    input wire [`CTMB_ADDR_W-1:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    input wire [31:0] regRdData_ff,
    input wire [2:0] newReq,
    input wire [2:0] txSuccess,
    input wire [2:0] txRelease,
    input wire [2:0] cancelReq,
    input wire [2:0] mboxPending,
    input wire orderByReq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire [1:0] freeIdx;
    wire [1:0] lowIdx;
    assign freeIdx = !mboxPending[0] ? 2'h0 : (!mboxPending[1] ? 2'h1 : 2'h2);
    assign lowIdx = regRdData_ff[31] ? 2'h2 : (regRdData_ff[30] ? 2'h1 : 2'h0);
    // ==========================================================
    // sequences
    sequence s_rd_sts;
        regRdEn && regAddr == `CTMB_TSTS_OFF;
    endsequence
    sequence s_wr_sts;
        regWrEn && regAddr == `CTMB_TSTS_OFF;
    endsequence
    // ==========================================================
    // properties
    property p_rd_empty;
        s_rd_sts |=> regRdData_ff[28:26] == ~$past(mboxPending);
    endproperty
    property p_lp_few;
        s_rd_sts ##0 $countones(mboxPending) < 2 |=> regRdData_ff[31:29] == 3'h0;
    endproperty
    property p_lp_one;
        s_rd_sts ##0 $countones(mboxPending) >= 2 |=>
            $onehot(regRdData_ff[31:29]) && (regRdData_ff[31:29] & ~$past(mboxPending)) == 3'h0;
    endproperty
    property p_nr_free;
        s_rd_sts ##0 mboxPending != 3'h7 |=> regRdData_ff[25:24] == $past(freeIdx);
    endproperty
    property p_nr_full;
        s_rd_sts ##0 mboxPending == 3'h7 |=> regRdData_ff[25:24] == lowIdx;
    endproperty
    property p_cancel_pend;
        (cancelReq & ~mboxPending) == 3'h0;
    endproperty
    property p_cancel_set;
        s_wr_sts ##0 (regWrData[15] && mboxPending[1] && !txSuccess[1] && !txRelease[1]) |=> cancelReq[1];
    endproperty
    property p_req_pend;
        newReq != 3'h0 |=> (mboxPending & $past(newReq)) == $past(newReq);
    endproperty
    property p_order;
        regWrEn && regAddr == `CTMB_CTRL_OFF |=> orderByReq == $past(regWrData[2]);
    endproperty
    a_rd_empty: assert property (p_rd_empty) else $error("empty flags differ from pending");
    a_lp_few: assert property (p_lp_few) else $error("lowest flag with under two pending");
    a_lp_one: assert property (p_lp_one) else $error("lowest flag not one pending mailbox");
    a_nr_free: assert property (p_nr_free) else $error("number field not next free mailbox");
    a_nr_full: assert property (p_nr_full) else $error("number field not lowest mailbox");
    a_cancel_pend: assert property (p_cancel_pend) else $error("cancel on a free mailbox");
    a_cancel_set: assert property (p_cancel_set) else $error("cancel write not taken");
    a_req_pend: assert property (p_req_pend) else $error("request left mailbox empty");
    a_order: assert property (p_order) else $error("order rule not written");
endmodule // ctmb_tx_status_props
`default_nettype wire

// >>> verification/ctmb_engine_model.sv
// Purpose: behavioural protocol engine beside the status block
// Assumes: bench calls request and pulse
// Notes: abort latency is adjustable to act prompt or slow
`timescale 1ns/1ns
`default_nettype none

module ctmb_engine_model #(
    parameter ID_W = 29
) (
    input wire mclk,
    input wire [2:0] cancelReq,
    input wire [2:0] mboxPending,
    output var logic [2:0] newReq,
    output wire [ID_W-1:0] reqId0,
    output wire [ID_W-1:0] reqId1,
    output wire [ID_W-1:0] reqId2,
    output wire [2:0] txStart,
    output wire [2:0] txSuccess,
    output wire [2:0] txArbLost,
    output wire [2:0] txError,
    output var logic [2:0] txRelease
);
    logic [ID_W-1:0] ids [3];
    logic [11:0] evt;
    int abortLat;
    int waitCnt [3];
    assign reqId0 = ids[0];
    assign reqId1 = ids[1];
    assign reqId2 = ids[2];
    assign {txError, txArbLost, txSuccess, txStart} = evt;
    initial begin
        newReq = 3'h0;
        evt = 12'h000;
        txRelease = 3'h0;
        abortLat = 0;
        ids = '{default: '0};
        waitCnt = '{default: 0};
    end
    task automatic request(input int mb, input logic [ID_W-1:0] id);
        @(posedge mclk);
        newReq[mb] <= 1'b1;
        ids[mb] <= id;
        @(posedge mclk);
        newReq <= 3'h0;
        // identifier no longer sampled: show garbage, not the old value
        ids[mb] <= ~id;
    endtask
    task automatic pulse(input int kind, input int mb);
        @(posedge mclk);
        evt[kind*3+mb] <= 1'b1;
        @(posedge mclk);
        evt <= 12'h000;
    endtask
    // ==========================================================
    // abort of a cancelled mailbox
    always @(posedge mclk) begin
        txRelease <= 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (cancelReq[i] && mboxPending[i] && !txRelease[i]) begin
                if (waitCnt[i] >= abortLat) begin
                    txRelease[i] <= 1'b1;
                    waitCnt[i] <= 0;
                end else begin
                    waitCnt[i] <= waitCnt[i] + 1;
                end
            end
        end
    end
endmodule // ctmb_engine_model
`default_nettype wire

// >>> verification/ctmb_tx_status_tb_top.sv
// Purpose: register-level tests of the transmit mailbox status block
// Assumes: engine model drives all mailbox events
// Notes: expected words are built from the field layout
`timescale 1ns/1ns
`default_nettype none
`include "ctmb_defs.vh"

module ctmb_tx_status_tb_top;
    localparam logic [9:0] CTRL = `CTMB_CTRL_OFF;
    localparam logic [9:0] TSTS = `CTMB_TSTS_OFF;
    localparam int EV_START = 0;
    localparam int EV_SUCC = 1;
    localparam int EV_ARB = 2;
    localparam int EV_ERR = 3;
    logic mclk;
    logic rstn;
    logic [9:0] regAddr;
    logic [31:0] regWrData;
    logic regWrEn;
    logic regRdEn;
    wire [31:0] regRdData_ff;
    wire [2:0] newReq, txStart, txSuccess, txArbLost, txError, txRelease, cancelReq, mboxPending;
    wire [28:0] reqId0, reqId1, reqId2;
    wire orderByReq;
    wire irq;
    int errors;
    int checks;
    logic [31:0] rdv;

    ctmb_tx_status dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff), .newReq(newReq),
        .reqId0(reqId0), .reqId1(reqId1), .reqId2(reqId2), .txStart(txStart), .txSuccess(txSuccess),
        .txArbLost(txArbLost), .txError(txError), .txRelease(txRelease), .cancelReq(cancelReq),
        .mboxPending(mboxPending), .orderByReq(orderByReq), .irq(irq));
    ctmb_engine_model eng (.mclk(mclk), .cancelReq(cancelReq), .mboxPending(mboxPending),
        .newReq(newReq), .reqId0(reqId0), .reqId1(reqId1), .reqId2(reqId2), .txStart(txStart),
        .txSuccess(txSuccess), .txArbLost(txArbLost), .txError(txError), .txRelease(txRelease));

    always #20 mclk = ~mclk;
    // ==========================================================
    // access and compare tasks
    task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmpPin(input string name, input logic [2:0] exp, input logic [2:0] got);
        cmp32(name, {29'h0, exp}, {29'h0, got});
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrEn <= 1'b0;
        #1;
    endtask
    task automatic rdChk(input string name, input logic [9:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1;
        rdv = regRdData_ff;
        cmp32(name, exp, rdv);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        results();
    end
    // ==========================================================
    // tests
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        regAddr = 10'h000;
        regWrData = 32'h0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        errors = 0;
        checks = 0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        rdChk("status reset", TSTS, 32'h1C00_0000);
        rdChk("ctrl reset", CTRL, 32'h0);
        rdChk("unmapped", 10'h0FC, 32'h0);
        eng.request(0, 29'h400);
        rdChk("mb0 pending", TSTS, 32'h1900_0000);
        eng.pulse(EV_START, 0);
        eng.pulse(EV_SUCC, 0);
        rdChk("mb0 done", TSTS, 32'h1C00_0003);
        rdChk("irq status", `CTMB_IRQ_STS_OFF, 32'h1);
        cmpPin("irq masked", 3'h0, {2'h0, irq});
        wr(`CTMB_IRQ_EN_OFF, 32'h1);
        cmpPin("irq enabled", 3'h1, {2'h0, irq});
        wr(`CTMB_IRQ_CLR_OFF, 32'h1);
        cmpPin("irq cleared", 3'h0, {2'h0, irq});
        wr(TSTS, 32'hFF70_7070);
        rdChk("zero and reserved", TSTS, 32'h1C00_0003);
        wr(TSTS, 32'h1);
        rdChk("complete w1c", TSTS, 32'h1C00_0000);
        eng.request(1, 29'h433);
        eng.pulse(EV_ARB, 1);
        rdChk("arb lost", TSTS, 32'h1400_0400);
        eng.pulse(EV_ERR, 1);
        rdChk("tx error", TSTS, 32'h1400_0C00);
        eng.pulse(EV_START, 1);
        rdChk("start clears", TSTS, 32'h1400_0000);
        eng.pulse(EV_ERR, 1);
        wr(TSTS, 32'h0000_0800);
        rdChk("error w1c", TSTS, 32'h1400_0000);
        eng.abortLat = 4;
        wr(TSTS, 32'h0080_8000);
        cmpPin("cancel", 3'h2, cancelReq);
        repeat (12) @(posedge mclk);
        rdChk("aborted", TSTS, 32'h1C00_0100);
        eng.request(1, 29'h433);
        eng.request(2, 29'h411);
        eng.request(0, 29'h400);
        rdChk("id order", TSTS, 32'h4100_0000);
        wr(CTRL, 32'h4);
        cmpPin("order pin", 3'h1, {2'h0, orderByReq});
        rdChk("ctrl", CTRL, 32'h4);
        rdChk("request order", TSTS, 32'h2000_0000);
        eng.pulse(EV_SUCC, 0);
        rdChk("two pending", TSTS, 32'h8400_0003);
        cmpPin("irq again", 3'h1, {2'h0, irq});
        eng.pulse(EV_ERR, 0);
        wr(TSTS, 32'h0);
        rdChk("mb0 zero write", TSTS, 32'h8400_0009);
        wr(TSTS, 32'h8);
        rdChk("mb0 error w1c", TSTS, 32'h8400_0001);
        rdChk("irq enable", `CTMB_IRQ_EN_OFF, 32'h1);
        results();
    end
endmodule // ctmb_tx_status_tb_top

bind ctmb_tx_status ctmb_tx_status_props u_props (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
    .newReq(newReq), .txSuccess(txSuccess), .txRelease(txRelease), .cancelReq(cancelReq),
    .mboxPending(mboxPending), .orderByReq(orderByReq));
`default_nettype wire
